// ==== sltfc_pkg.sv ====
// sltfc_pkg: constants and types for the serial link transmit frame control.
// assumes a 20 MHz pclk and an apb master with 32-bit data.
package sltfc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FRAMES = 8'h0c;

  // control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_EXT_SERIAL_CLOCK_SEL = 0;
  localparam int CTRL_FILL_TYPE_SEL = 1;
  localparam int CTRL_EXTRA_BIT_MODE_SEL = 2;
  localparam int CTRL_MONITOR_POWER_ON = 3;
  localparam int CTRL_WIDE_WORD_SEL = 4;
  localparam logic [4:0] CTRL_RESET = 5'h08;

  // vco divider register: pclk cycles per serial bit
  localparam int DIV_W = 8;
  localparam logic [7:0] DIV_RESET = 8'h01;

  // status register fields
  localparam int STAT_BAL_LSB = 0;
  localparam int STAT_LEVEL_LSB = 8;
  localparam int STAT_KIND_LSB = 12;
  localparam int STAT_INV = 15;
  localparam int STAT_FLAG = 16;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam int DATA_W = 20;
  localparam int NARROW_W = 16;
  localparam int CODE_BITS = 4;
  localparam logic [4:0] BITS_WIDE = 5'h18;
  localparam logic [4:0] BITS_NARROW = 5'h14;
  localparam int BAL_W = 8;
  localparam int CNT_W = 16;

  // fifo in the data path: {ctrl, flag, data}
  localparam int FIFO_W = DATA_W + 2;
  localparam int FIFO_DEPTH = 8;
  localparam int LEVEL_W = 4;

  typedef enum logic [2:0] {
    SLTFC_DATA,
    SLTFC_CTRL,
    SLTFC_FILL0,
    SLTFC_FILL1A,
    SLTFC_FILL1B
  } sltfc_kind_t;

endpackage

// ==== sltfc_fifo.sv ====
// sltfc_fifo: synchronous valid/ready fifo, width and depth as parameters.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module sltfc_fifo #(
  parameter int W = 22,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [AW:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } sltfc_fifo_state_t;

  sltfc_fifo_state_t s_q, s_d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////////
  assign in_ready = (s_q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign level = s_q.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    // simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== sltfc_top.sv ====
// sltfc_top: transmit frame selection, flag handling, dc balance and
// serial clock selection/monitor, with apb control registers.
// assumes the data source and control inputs are synchronous to pclk;
// parallel_strobe_in is sampled as an ordinary input.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
// Contract
// - external clock select makes the strobe input the serial clock
// - fill frame sent when no request or link-up enable is false
// - fill type low gives zero fill, high gives one-type fill
// - one-type fill variant chosen by the cumulative dc balance
// - extra-bit mode high sends the extra bit as transparent data
// - extra-bit mode low ignores it and alternates the flag per frame
// - control frames never carry the extra bit as data
// - clock monitor shows the divided clock actually used
// - monitor power off drives both monitor outputs low
// - inversion indicator high exactly for frames sent inverted
// - control and data requested together gives a control frame
// - data sent only while link-up enable says both ends are locked
// - 20 data bits when wide word select, else the low 16
module sltfc_top
  import sltfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [sltfc_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic parallel_strobe_in,
  input wire logic link_up_enable,
  input wire logic ctrl_word_avail_n,
  input wire logic data_avail_n,
  input wire logic [sltfc_pkg::DATA_W-1:0] data_in,
  input wire logic flag_in,
  output logic ready_for_data,
  output logic frame_valid,
  output sltfc_pkg::sltfc_kind_t frame_kind,
  output logic [sltfc_pkg::DATA_W-1:0] frame_data,
  output logic frame_flag,
  output logic frame_complement_out,
  output logic serial_clock_mon,
  output logic serial_clock_mon_n
);
  import sltfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] div_cnt;
    logic strobe_prev;
    logic [4:0] bit_cnt;
    logic mon;
    logic mon_p;
    logic mon_n;
    logic alt;
    logic signed [BAL_W-1:0] bal;
    logic [CNT_W-1:0] frames;
    logic [31:0] rdata;
    logic fv;
    sltfc_kind_t kind;
    logic [DATA_W-1:0] fdata;
    logic fflag;
    logic finv;
  } sltfc_state_t;

  sltfc_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  // fifo in the data path

  logic fifo_in_valid, fifo_in_ready;
  logic fifo_out_valid, fifo_out_ready;
  logic [FIFO_W-1:0] fifo_in_data, fifo_out_data;
  logic [LEVEL_W-1:0] fifo_level;
  logic req_ctrl;

  // control wins when both requests are low together
  assign req_ctrl = !ctrl_word_avail_n;
  assign fifo_in_valid = !ctrl_word_avail_n || !data_avail_n;
  assign fifo_in_data = {req_ctrl, flag_in, data_in};
  // no words are accepted until the link reports lock at both ends
  assign ready_for_data = fifo_in_ready && link_up_enable;

  sltfc_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .AW(LEVEL_W - 1)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_in_valid && link_up_enable),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial clock source and frame timing

  logic ext_sel, wide, vco_tick, ext_tick, ser_tick, frame_tick;
  logic [4:0] frame_bits;

  assign ext_sel = s_q.ctrl[CTRL_EXT_SERIAL_CLOCK_SEL];
  assign wide = s_q.ctrl[CTRL_WIDE_WORD_SEL];
  assign vco_tick = ({1'b0, s_q.div_cnt} + 9'h001) >= {1'b0, s_q.div};
  // a rising strobe edge stands in for the vco in diagnostic mode
  assign ext_tick = parallel_strobe_in && !s_q.strobe_prev;
  assign ser_tick = ext_sel ? ext_tick : vco_tick;
  assign frame_bits = wide ? BITS_WIDE : BITS_NARROW;
  assign frame_tick = ser_tick && (s_q.bit_cnt == frame_bits - 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // word masking and disparity

  logic [DATA_W-1:0] word_mask, word_bits;
  logic head_ctrl, head_flag, send_flag, link_ok;
  logic [4:0] ones, nbits;
  logic signed [BAL_W-1:0] disp;
  logic invert;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_mask
      // upper four bits only travel in wide mode
      assign word_mask[gi] = (gi < NARROW_W) || wide;
    end
  endgenerate

  assign word_bits = fifo_out_data[DATA_W-1:0] & word_mask;
  assign head_ctrl = fifo_out_data[DATA_W+1];
  assign head_flag = fifo_out_data[DATA_W];
  assign link_ok = link_up_enable && fifo_out_valid;

  always_comb begin
    if (head_ctrl) begin
      send_flag = 1'b0;
    end else if (s_q.ctrl[CTRL_EXTRA_BIT_MODE_SEL]) begin
      send_flag = head_flag;
    end else begin
      send_flag = s_q.alt;
    end
  end

  function automatic logic [4:0] pop_count(input logic [DATA_W:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i <= DATA_W; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // a control frame has no flag bit, so it is left out of the count
  assign ones = pop_count({send_flag && !head_ctrl, word_bits});
  assign nbits = (wide ? 5'(DATA_W) : 5'(NARROW_W)) + {4'h0, !head_ctrl};
  assign disp = $signed({2'b00, ones, 1'b0}) - $signed({3'b000, nbits});
  // invert when the frame would push the balance further the same way
  assign invert = (s_q.bal != '0) && (disp != '0) &&
                  (s_q.bal[BAL_W-1] == disp[BAL_W-1]);

  assign fifo_out_ready = frame_tick && link_up_enable;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setup, wr_en, mapped;
  logic [31:0] stat_word;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_DIV) ||
                  (paddr == REG_STATUS) || (paddr == REG_FRAMES);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    stat_word = '0;
    stat_word[STAT_BAL_LSB +: BAL_W] = s_q.bal;
    stat_word[STAT_LEVEL_LSB +: LEVEL_W] = fifo_level;
    stat_word[STAT_KIND_LSB +: 3] = s_q.kind;
    stat_word[STAT_INV] = s_q.finv;
    stat_word[STAT_FLAG] = s_q.fflag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.fv = 1'b0;
    s_d.strobe_prev = parallel_strobe_in;

    // registers
    if (wr_en && paddr == REG_CTRL) begin
      s_d.ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr_en && paddr == REG_DIV) begin
      s_d.div = pwdata[DIV_W-1:0];
    end
    if (setup) begin
      case (paddr)
        REG_CTRL: s_d.rdata = {27'h0, s_q.ctrl};
        REG_DIV: s_d.rdata = {24'h0, s_q.div};
        REG_STATUS: s_d.rdata = stat_word;
        REG_FRAMES: s_d.rdata = {16'h0, s_q.frames};
        default: s_d.rdata = 32'h0;
      endcase
    end

    // serial bit timing
    if (vco_tick) begin
      s_d.div_cnt = '0;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 8'h01;
    end
    if (ser_tick) begin
      s_d.mon = !s_q.mon;
      s_d.bit_cnt = frame_tick ? 5'h00 : s_q.bit_cnt + 5'h01;
    end
    // both monitor legs go quiet when powered down
    if (s_q.ctrl[CTRL_MONITOR_POWER_ON]) begin
      s_d.mon_p = s_d.mon;
      s_d.mon_n = !s_d.mon;
    end else begin
      s_d.mon_p = 1'b0;
      s_d.mon_n = 1'b0;
    end

    // one decision per frame, applied to that frame only
    if (frame_tick) begin
      s_d.fv = 1'b1;
      s_d.frames = s_q.frames + 16'h0001;
      s_d.alt = !s_q.alt;
      if (!link_ok) begin
        s_d.fdata = '0;
        s_d.fflag = s_q.alt;
        s_d.finv = 1'b0;
        if (!s_q.ctrl[CTRL_FILL_TYPE_SEL]) begin
          s_d.kind = SLTFC_FILL0;
        end else if (s_q.bal[BAL_W-1]) begin
          s_d.kind = SLTFC_FILL1A;
        end else begin
          s_d.kind = SLTFC_FILL1B;
        end
      end else begin
        s_d.kind = head_ctrl ? SLTFC_CTRL : SLTFC_DATA;
        s_d.finv = invert;
        if (invert) begin
          s_d.fdata = ~word_bits & word_mask;
          s_d.fflag = head_ctrl ? 1'b0 : !send_flag;
          s_d.bal = s_q.bal - disp;
        end else begin
          s_d.fdata = word_bits;
          s_d.fflag = send_flag;
          s_d.bal = s_q.bal + disp;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{ctrl: CTRL_RESET, div: DIV_RESET, kind: SLTFC_FILL0,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s_q.rdata;
  assign frame_valid = s_q.fv;
  assign frame_kind = s_q.kind;
  assign frame_data = s_q.fdata;
  assign frame_flag = s_q.fflag;
  assign frame_complement_out = s_q.finv;
  assign serial_clock_mon = s_q.mon_p;
  assign serial_clock_mon_n = s_q.mon_n;

endmodule

// ==== sltfc_asserts.sv ====
// sltfc_asserts: port-level checks for sltfc_top.
// assumes it is bound to sltfc_top and sees only its ports.
`timescale 1ns/100ps
module sltfc_asserts
  import sltfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_up_enable,
  input wire logic ready_for_data,
  input wire logic frame_valid,
  input sltfc_pkg::sltfc_kind_t frame_kind,
  input wire logic [sltfc_pkg::DATA_W-1:0] frame_data,
  input wire logic frame_flag,
  input wire logic frame_complement_out,
  input wire logic serial_clock_mon,
  input wire logic serial_clock_mon_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////
  sequence frame_pulse;
    frame_valid;
  endsequence
  sequence fill_pulse;
    frame_valid && frame_kind != SLTFC_DATA && frame_kind != SLTFC_CTRL;
  endsequence
  link_gate_a: assert property (
    !link_up_enable |-> !ready_for_data) else $error("rfd with link down");
  fill_down_a: assert property (
    frame_pulse ##0 !$past(link_up_enable) |-> frame_kind inside
    {SLTFC_FILL0, SLTFC_FILL1A, SLTFC_FILL1B}) else $error("no fill");
  fill_zero_a: assert property (
    fill_pulse |-> frame_data == '0) else $error("fill data not zero");
  ctrl_flag_a: assert property (
    frame_pulse ##0 frame_kind == SLTFC_CTRL |-> !frame_flag)
    else $error("ctrl flag carried");
  frame_gap_a: assert property (
    frame_pulse |=> !frame_valid [*8]) else $error("frames too close");
  frame_hold_a: assert property (
    !frame_valid |-> $stable({frame_kind, frame_data, frame_flag,
    frame_complement_out})) else $error("frame changed between frames");
  mon_pair_a: assert property (
    !(serial_clock_mon && serial_clock_mon_n)) else $error("monitor both");
  mon_rate_a: assert property (
    $rose(serial_clock_mon) |=> !$rose(serial_clock_mon))
    else $error("monitor faster than tick/2");
endmodule

// ==== sltfc_src.sv ====
// sltfc_src: user data source model on the request side of sltfc_top.
// assumes pclk as its clock; holds each request until it is taken or 9000 cycles pass.
`timescale 1ns/100ps
module sltfc_src (
  input wire logic pclk,
  input wire logic ready_for_data,
  output logic ctrl_word_avail_n,
  output logic data_avail_n,
  output logic [19:0] data_in,
  output logic flag_in
);
  logic late = 0;
  initial begin
    ctrl_word_avail_n = 1'b1;
    data_avail_n = 1'b1;
    data_in = 20'h0;
    flag_in = 1'b0;
  end
  // runs on the link's own clock, never asks the link to follow it
  task send(input logic c, input logic [19:0] d, input logic f);
    int i;
    @(posedge pclk);
    ctrl_word_avail_n <= !c;
    data_avail_n <= 1'b0;
    data_in <= d;
    flag_in <= f;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!ready_for_data && i < 9000);
    late |= !ready_for_data;
    // released lines show garbage, not the last word
    ctrl_word_avail_n <= 1'b1;
    data_avail_n <= 1'b1;
    data_in <= ~d;
    flag_in <= ~f;
  endtask
endmodule

// ==== serial_link_tx_frame_control_test.sv ====
// serial_link_tx_frame_control_test: directed bench for sltfc_top.
// assumes sltfc_src as data source and the checker bound below.
`timescale 1ns/100ps
module serial_link_tx_frame_control_test;
  import sltfc_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, ready_for_data, frame_valid, frame_flag;
  logic parallel_strobe_in = 0, link_up_enable = 0, strobe_on = 0;
  logic frame_complement_out, serial_clock_mon, serial_clock_mon_n;
  logic ctrl_word_avail_n, data_avail_n, flag_in;
  logic [19:0] data_in, frame_data;
  sltfc_kind_t frame_kind;
  int error_cnt = 0, n_tests = 0;
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (strobe_on) parallel_strobe_in <= ~parallel_strobe_in;
  end
  sltfc_top i_dut(.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .parallel_strobe_in,
    .link_up_enable, .ctrl_word_avail_n, .data_avail_n, .data_in, .flag_in,
    .ready_for_data, .frame_valid, .frame_kind, .frame_data, .frame_flag,
    .frame_complement_out, .serial_clock_mon, .serial_clock_mon_n);
  sltfc_src i_src(.pclk, .ready_for_data, .ctrl_word_avail_n,
    .data_avail_n, .data_in, .flag_in);
  //////////////////////////////////////////
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task hang;
    error_cnt++;
    end_of_test();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!pready && i < 16);
    if (!pready) hang();
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wfr(input int n);
    int i;
    i = 0;
    do begin
      @(negedge pclk);
      i++;
    end while (!frame_valid && i < n);
    if (!frame_valid) hang();
  endtask
  //////////////////////////////////////////
  task t_regs;
    apb(0, REG_CTRL, 0);
    chk(q, 32'(CTRL_RESET));
    apb(0, REG_DIV, 0);
    chk(q, 32'(DIV_RESET));
    apb(0, 8'h10, 0);
    chk(e, 1);
  endtask
  task t_fifo;
    int k;
    logic [15:0] base;
    apb(1, REG_DIV, 255);
    apb(1, REG_CTRL, 32'h1c);
    link_up_enable <= 1;
    for (k = 0; k < 8; k++) i_src.send(0, 20'hfff00 + 20'(k), k[1]);
    @(negedge pclk);
    chk(ready_for_data, 0);
    apb(0, REG_STATUS, 0);
    chk(q[11:8], 8);
    apb(0, REG_FRAMES, 0);
    base = q[15:0];
    apb(1, REG_DIV, 1);
    for (k = 0; k < 8; k++) begin
      wfr(6000);
      chk(frame_kind, SLTFC_DATA);
      chk(frame_data ^ {20{frame_complement_out}}, 32'hfff00 + k);
      chk(frame_flag ^ frame_complement_out, k[1]);
      // balance runs 0,3,-2,5,-4,1,-6,3: odd frames go out inverted
      chk(frame_complement_out, k[0]);
    end
    chk(ready_for_data, 1);
    apb(0, REG_FRAMES, 0);
    chk(16'(q[15:0] - base), 16'h0008);
  endtask
  task t_fill;
    logic f;
    apb(1, REG_CTRL, 32'h08);
    link_up_enable <= 0;
    wfr(100);
    f = frame_flag;
    chk(ready_for_data, 0);
    wfr(100);
    chk(frame_kind, SLTFC_FILL0);
    chk(frame_flag, !f);
    apb(1, REG_CTRL, 32'h0a);
    apb(0, REG_STATUS, 0);
    // fills leave the balance where the eighth data frame put it
    chk(q[7:0], 8'hf8);
    wfr(100);
    chk(frame_kind, SLTFC_FILL1A);
  endtask
  task t_ctrl;
    apb(1, REG_CTRL, 32'h0c);
    link_up_enable <= 1;
    i_src.send(1, 20'hfffff, 1);
    wfr(100);
    if (frame_kind > SLTFC_CTRL) wfr(100);
    chk(frame_kind, SLTFC_CTRL);
    chk(frame_flag, 0);
    chk(frame_data, 20'h0ffff);
    chk(frame_complement_out, 0);
    i_src.send(0, 20'hfffff, 1);
    wfr(100);
    if (frame_kind > SLTFC_CTRL) wfr(100);
    chk(frame_kind, SLTFC_DATA);
    chk(frame_data, 0);
    chk({frame_complement_out, frame_flag}, 2'b10);
  endtask
  task t_mon;
    logic m;
    apb(1, REG_CTRL, 32'h00);
    repeat (4) @(negedge pclk);
    chk({serial_clock_mon, serial_clock_mon_n}, 0);
    apb(1, REG_CTRL, 32'h08);
    repeat (4) @(negedge pclk);
    m = serial_clock_mon;
    @(negedge pclk);
    chk({serial_clock_mon, serial_clock_mon_n}, {~m, m});
    apb(1, REG_CTRL, 32'h09);
    repeat (40) @(negedge pclk);
    m = serial_clock_mon;
    repeat (40) @(negedge pclk);
    chk(serial_clock_mon, m);
    @(posedge pclk);
    strobe_on <= 1;
    wfr(200);
    m = serial_clock_mon;
    repeat (2) @(negedge pclk);
    chk(serial_clock_mon, !m);
    @(posedge pclk);
    strobe_on <= 0;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_fifo();
    t_fill();
    t_ctrl();
    t_mon();
    chk(i_src.late, 0);
    end_of_test();
  end
endmodule
bind sltfc_top sltfc_asserts i_chk(.pclk, .presetn, .link_up_enable,
  .ready_for_data, .frame_valid, .frame_kind, .frame_data, .frame_flag,
  .frame_complement_out, .serial_clock_mon, .serial_clock_mon_n);
